// file: dv/lapc_ep_model.sv
`timescale 1ns/1ps
// endpoint: request stream, idle set after acceptance
module lapc_ep_model #(
  parameter int IDLE_DLY = 4
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic go,
  input wire logic send_ack,
  input wire logic send_nak,
  output logic rx_req_l1,
  output logic rx_eidle
);
  bit answered_r;
  int ack_cnt_r;
  // request repeats until answered
  always_ff @(posedge core_clk) begin
    answered_r <= (reset || !go) ? 1'b0 : answered_r | send_ack | send_nak;
  end
  assign rx_req_l1 = go && !answered_r;
  // idle set once the ack stream has run a while
  always_ff @(posedge core_clk) begin
    ack_cnt_r <= (reset || !send_ack) ? 0 : ack_cnt_r + 1;
  end
  assign rx_eidle = send_ack && ack_cnt_r == IDLE_DLY;
endmodule

// file: dv/lapc_port_asserts.sv
`timescale 1ns/1ps
module lapc_port_asserts
  import lapc_pkg::*;
#(
  parameter int EXP_PERIOD = EXP_PERIOD_CYC
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic upstream_mode,
  input wire lapc_pkg::lapc_ltssm_t ltssm_state,
  input wire logic tlp_pending,
  input wire logic partner_exit,
  input wire logic rx_req_l1,
  input wire logic rx_eidle,
  input wire logic l1_exit_req,
  input wire logic send_ack,
  input wire logic send_nak,
  input wire logic enter_l1,
  input wire logic port_link_up_indicator,
  input wire logic port_activity_indicator
);
  localparam int EXIT_MAX = EXIT_LATENCY_CYC;
  int chg_cnt;
  int low_cnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // cycles since an indicator moved, and length of the activity pulse
  always_ff @(posedge core_clk) begin
    chg_cnt <= (reset || $changed({port_link_up_indicator, port_activity_indicator}))
      ? 0 : chg_cnt + 1;
  end
  always_ff @(posedge core_clk) begin
    low_cnt <= (reset || port_activity_indicator) ? 0 : low_cnt + 1;
  end
  // idle set arriving during acceptance
  sequence s_idle_seen;
    send_ack && rx_eidle;
  endsequence
  exit_on_tlp_a: assert property (ltssm_state == LTS_L1 && tlp_pending |=> l1_exit_req)
    else $error("no exit on packet");
  exit_follow_a: assert property (
    ltssm_state == LTS_L1 && partner_exit |-> ##[1:EXIT_MAX] l1_exit_req)
    else $error("exit follow late");
  answer_cause_a: assert property (
    $rose(send_ack) || send_nak |-> $past(rx_req_l1) && !$past(upstream_mode))
    else $error("answer without request");
  nak_gap_a: assert property (send_nak |=> !(send_ack || send_nak) [*8])
    else $error("answer in gap");
  ack_hold_a: assert property (
    send_ack && !rx_eidle && !tlp_pending && ltssm_state == LTS_L0 |=> send_ack)
    else $error("ack dropped");
  enter_a: assert property (s_idle_seen |=> enter_l1 && !send_ack)
    else $error("no entry");
  pace_a: assert property (
    $changed({port_link_up_indicator, port_activity_indicator}) |-> chg_cnt >= EXP_PERIOD - 1)
    else $error("indicator too fast");
  act_hold_a: assert property (
    $rose(port_activity_indicator) |-> low_cnt >= ACT_HOLD_PERIODS * EXP_PERIOD - 1)
    else $error("activity short");
endmodule
bind lapc_port lapc_port_asserts #(.EXP_PERIOD(EXP_PERIOD)) u_chk (.core_clk, .reset,
  .upstream_mode, .ltssm_state, .tlp_pending, .partner_exit, .rx_req_l1, .rx_eidle,
  .l1_exit_req, .send_ack, .send_nak, .enter_l1, .port_link_up_indicator,
  .port_activity_indicator);

// file: dv/tb_lapc_port.sv
`timescale 1ns/1ps
module tb_lapc_port;
  import lapc_pkg::*;
  localparam int P = 20;
  logic core_clk, reset, upstream_mode, tlp_pending, partner_exit, rx_active, tlp_vendor;
  logic reg_wr, reg_rd, go, rx_req_l1, rx_eidle, l1_exit_req, send_ack, send_nak, enter_l1;
  logic port_link_up_indicator, port_activity_indicator;
  logic [2:0] pv;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  lapc_ltssm_t ltssm_state;
  int n_errors, n_checks;
  wire nak_done = pv[2];
  wire tlp_rx = pv[1];
  wire tlp_tx = pv[0];
  wire [6:0] o = {~port_activity_indicator, ~port_link_up_indicator, enter_l1,
    send_ack | send_nak, send_nak, send_ack, l1_exit_req};
  lapc_port #(.EXP_PERIOD(P)) u_dut (.core_clk, .reset, .upstream_mode, .ltssm_state,
    .tlp_pending, .partner_exit, .rx_req_l1, .rx_eidle, .rx_active, .nak_done, .tlp_tx,
    .tlp_rx, .tlp_vendor, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .l1_exit_req, .send_ack, .send_nak, .enter_l1, .port_link_up_indicator,
    .port_activity_indicator);
  lapc_ep_model #(.IDLE_DLY(6)) u_ep (.core_clk, .reset, .go, .send_ack, .send_nak,
    .rx_req_l1, .rx_eidle);
  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic c, input string m);
    n_checks++;
    if (!c) begin
      n_errors++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  // output must hold a level for n cycles
  task automatic qt(input int b, input logic v, input int n, input string m);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      chk(o[b] === v, m);
    end
  endtask
  // bounded wait for an output level
  task automatic wt(input int b, input logic v, input int n, input string m);
    for (int i = 0; i < n && o[b] !== v; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk(o[b] === v, m);
    if (o[b] !== v) finish_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata === e, "read data");
  endtask
  task automatic pl(input int k);
    @(posedge core_clk);
    pv[k] <= 1'b1;
    @(posedge core_clk);
    pv[k] <= 1'b0;
  endtask
  // rejection, then an early retry that breaks the endpoint gap
  task automatic rj();
    tlp_pending <= 1'b1;
    go <= 1'b1;
    wt(2, 1'b1, 10, "no rejection");
    qt(2, 1'b0, 4, "extra rejection");
    go <= 1'b0;
    tlp_pending <= 1'b0;
    pl(2);
    go <= 1'b1;
  endtask
  task automatic ak();
    wt(4, 1'b1, 20, "no entry");
    chk(o[1] === 1'b0, "ack after entry");
    go <= 1'b0;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    {reset, upstream_mode, tlp_pending, partner_exit, rx_active, tlp_vendor} = 6'h20;
    {reg_wr, reg_rd, go, pv, reg_addr, reg_wdata} = '0;
    ltssm_state = LTS_L0;
    n_errors = 0;
    n_checks = 0;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rd(REJ_TIMER_OFS, 32'h5f);
    rd(8'h0c, 32'h0);
    go <= 1'b1;
    qt(3, 1'b0, 20, "answer while off");
    go <= 1'b0;
    wr(LINK_CTRL_OFS, 32'h2);
    rd(LINK_CTRL_OFS, 32'h2);
    wr(REJ_TIMER_OFS, 32'h3ff);
    rd(REJ_TIMER_OFS, 32'h280);
    wr(REJ_TIMER_OFS, 32'h0);
    rd(REJ_TIMER_OFS, 32'h1);
    wr(REJ_TIMER_OFS, 32'h3);
    rx_active <= 1'b1;
    rj();
    qt(3, 1'b0, 25, "answer in gap");
    wt(1, 1'b1, 20, "no accept");
    ak();
    wr(REJ_TIMER_OFS, 32'h10003);
    rd(REJ_TIMER_OFS, 32'h10003);
    rj();
    qt(3, 1'b0, 60, "answer, lanes busy");
    rx_active <= 1'b0;
    wt(1, 1'b1, 40, "no accept");
    ak();
    @(posedge core_clk);
    upstream_mode <= 1'b1;
    go <= 1'b1;
    qt(3, 1'b0, 20, "answer in upstream mode");
    go <= 1'b0;
    upstream_mode <= 1'b0;
    ltssm_state <= LTS_L1;
    tlp_pending <= 1'b1;
    wt(0, 1'b1, 5, "no exit");
    tlp_pending <= 1'b0;
    wt(0, 1'b0, 5, "exit stuck");
    partner_exit <= 1'b1;
    wt(0, 1'b1, EXIT_LATENCY_CYC, "no follow");
    partner_exit <= 1'b0;
    upstream_mode <= 1'b1;
    wt(0, 1'b0, 5, "exit stuck");
    partner_exit <= 1'b1;
    wt(0, 1'b1, EXIT_LATENCY_CYC, "no upstream follow");
    partner_exit <= 1'b0;
    upstream_mode <= 1'b0;
    wt(5, 1'b1, 3 * P, "link not up");
    tlp_vendor <= 1'b1;
    pl(1);
    tlp_vendor <= 1'b0;
    qt(6, 1'b0, 3 * P, "vendor activity");
    pl(1);
    wt(6, 1'b1, 3 * P, "no activity");
    repeat (3 * P) @(posedge core_clk);
    pl(0);
    qt(6, 1'b1, 4 * P, "activity short");
    wt(6, 1'b0, 8 * P, "activity stuck");
    ltssm_state <= LTS_DISABLED;
    wt(5, 1'b0, 3 * P, "link still up");
    rd(STATUS_OFS, 32'h00200200);
    finish_test();
  end
endmodule

// file: verilog/lapc_act_hold.sv
`timescale 1ns/1ps
// expander pacing and activity stretch
module lapc_act_hold
  import lapc_pkg::*;
#(
  parameter int PERIOD_CYC = EXP_PERIOD_CYC
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic tlp_seen,
  input wire logic link_up_now,
  output logic link_up_n,
  output logic active_n
);
  logic [EXP_W-1:0] tick_r;
  logic [HOLD_W-1:0] hold_r;
  logic pend_r;
  logic tick;

  assign tick = (tick_r == EXP_W'(PERIOD_CYC - 1));

  // update period counter
  always_ff @(posedge core_clk) begin
    if (reset) tick_r <= '0;
    else if (tick) tick_r <= '0;
    else tick_r <= tick_r + EXP_W'(1);
  end

  // activity captured between updates
  always_ff @(posedge core_clk) begin
    if (reset) pend_r <= 1'b0;
    else if (tick) pend_r <= 1'b0;
    else if (tlp_seen) pend_r <= 1'b1;
  end

  // hold count in update periods
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hold_r <= '0;
    end else if (tick) begin
      if (pend_r || tlp_seen) hold_r <= HOLD_W'(ACT_HOLD_PERIODS);
      else if (hold_r != '0) hold_r <= hold_r - HOLD_W'(1);
    end
  end

  // outputs change only on update ticks
  always_ff @(posedge core_clk) begin
    if (reset) begin
      link_up_n <= 1'b1;
      active_n <= 1'b1;
    end else if (tick) begin
      link_up_n <= !link_up_now;
      active_n <= !(pend_r || tlp_seen || hold_r > HOLD_W'(1));
    end
  end
endmodule

// file: verilog/lapc_gap_timer.sv
`timescale 1ns/1ps
// minimum-gap timer armed after a rejection
module lapc_gap_timer
  import lapc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic rx_active,
  input wire logic alt_mode,
  input wire logic [GAP_W-1:0] gap,
  output logic busy
);
  logic armed_r;
  logic running_r;
  logic [UNIT_W-1:0] unit_r;
  logic [GAP_W-1:0] left_r;

  // arming and counting in 100 ns units
  always_ff @(posedge core_clk) begin
    if (reset) begin
      armed_r <= 1'b0;
      running_r <= 1'b0;
      unit_r <= '0;
      left_r <= '0;
    end else if (start) begin
      armed_r <= 1'b1;
      running_r <= !alt_mode;
      unit_r <= '0;
      left_r <= gap;
    end else if (armed_r && !running_r) begin
      running_r <= !rx_active;
    end else if (running_r) begin
      if (unit_r == UNIT_W'(GAP_UNIT_CYC - 1)) begin
        unit_r <= '0;
        if (left_r <= GAP_W'(1)) begin
          armed_r <= 1'b0;
          running_r <= 1'b0;
        end
        left_r <= left_r - GAP_W'(1);
      end else begin
        unit_r <= unit_r + UNIT_W'(1);
      end
    end
  end

  assign busy = armed_r;
endmodule

// file: verilog/lapc_pkg.sv
package lapc_pkg;

  // core clock period
  localparam int CLK_PERIOD_PS = 10000;

  // exit propagation bound between partition ports
  localparam int EXIT_LATENCY_NS = 1000;
  localparam int EXIT_LATENCY_CYC = (EXIT_LATENCY_NS * 1000) / CLK_PERIOD_PS;

  // endpoint gap after a rejection while staying in L0
  localparam int EP_GAP_NS = 10000;

  // reject timer granularity and range, in 100 ns steps
  localparam int GAP_UNIT_NS = 100;
  localparam int GAP_UNIT_CYC = (GAP_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int GAP_W = 10;
  localparam logic [GAP_W-1:0] GAP_MIN = 10'h001;
  localparam logic [GAP_W-1:0] GAP_MAX = 10'h280;
  localparam logic [GAP_W-1:0] GAP_RST = 10'h05f;
  localparam int UNIT_W = 4;

  // activity hold and expander update period
  localparam int ACT_HOLD_MS = 200;
  localparam int EXP_PERIOD_MS = 40;
  localparam int EXP_PERIOD_CYC = (EXP_PERIOD_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  localparam int ACT_HOLD_PERIODS = ACT_HOLD_MS / EXP_PERIOD_MS;
  localparam int EXP_W = 32;
  localparam int HOLD_W = 3;

  // register map (word offsets are byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] LINK_CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] REJ_TIMER_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;

  // link_control_register fields
  localparam int ASPM_L1_BIT = 1;
  // l1_reject_timer_ctrl_reg fields
  localparam int GAP_LSB = 0;
  localparam int TSS_BIT = 16;

  // link training states
  typedef enum logic [3:0] {
    LTS_DETECT = 4'h0,
    LTS_POLLING = 4'h1,
    LTS_CONFIG = 4'h2,
    LTS_L0 = 4'h3,
    LTS_L0S = 4'h4,
    LTS_L1 = 4'h5,
    LTS_RECOVERY = 4'h6,
    LTS_DISABLED = 4'h7
  } lapc_ltssm_t;

  // entry request handshake states, gray on every transition except IDLE to NAK
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACK = 2'b01,
    ST_NAK = 2'b11,
    ST_GAP = 2'b10
  } lapc_state_t;

endpackage

// file: verilog/lapc_port.sv
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - downstream port exits L1 when TLP queued
// - follow upstream exit within 1 us
// - answer entry requests only when enabled
// - accept by repeating ack until idle
// - reject with exactly one nak message
// - reject when a TLP is queued
// - per-port gap timer, 100 ns to 64 us
// - requests inside gap are ignored
// - gap defaults to 9.5 us
// - default mode starts timer at nak
// - alternate mode waits for quiet receive lanes
// - link-up and activity outputs per port
// - link-up follows L0/L0s/L1/Recovery
// - activity on non-vendor TLPs
// - activity holds at least 200 ms
// - expander updates at most every 40 ms
// - upstream follows downstream exit within 1 us
module lapc_port
  import lapc_pkg::*;
#(
  parameter int EXP_PERIOD = EXP_PERIOD_CYC
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic upstream_mode,
  input wire lapc_pkg::lapc_ltssm_t ltssm_state,
  input wire logic tlp_pending,
  input wire logic partner_exit,
  input wire logic rx_req_l1,
  input wire logic rx_eidle,
  input wire logic rx_active,
  input wire logic nak_done,
  input wire logic tlp_tx,
  input wire logic tlp_rx,
  input wire logic tlp_vendor,
  input wire logic [lapc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic l1_exit_req,
  output logic send_ack,
  output logic send_nak,
  output logic enter_l1,
  output logic port_link_up_indicator,
  output logic port_activity_indicator
);
  import lapc_pkg::*;

  lapc_state_t state_r;
  logic aspm_l1_en_r;
  logic aspm_other_r;
  logic [GAP_W-1:0] min_l1_request_gap_r;
  logic timer_start_select_r;
  logic req_seen_r;
  logic [31:0] acc_cnt_r;
  logic [31:0] rej_cnt_r;
  logic [31:0] rd_nxt;
  logic gap_busy;
  logic gap_start;
  logic new_req;
  logic in_l1;
  logic link_up_now;
  logic tlp_seen;
  logic [GAP_W-1:0] wgap;

  assign in_l1 = (ltssm_state == LTS_L1);
  assign link_up_now = (ltssm_state == LTS_L0) || (ltssm_state == LTS_L0S) ||
                       (ltssm_state == LTS_L1) || (ltssm_state == LTS_RECOVERY);
  assign tlp_seen = (tlp_tx || tlp_rx) && !tlp_vendor;
  assign wgap = reg_wdata[GAP_LSB +: GAP_W];

  // a request counts only once the gap has passed and on a fresh arrival
  assign new_req = rx_req_l1 && !gap_busy && !req_seen_r && !upstream_mode;
  assign gap_start = (state_r == ST_NAK) && nak_done;

  // link control register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      aspm_l1_en_r <= 1'b0;
      aspm_other_r <= 1'b0;
    end else if (reg_wr && reg_addr == LINK_CTRL_OFS) begin
      aspm_l1_en_r <= reg_wdata[ASPM_L1_BIT];
      aspm_other_r <= reg_wdata[0];
    end
  end

  // reject timer control register, gap clamped into range
  always_ff @(posedge core_clk) begin
    if (reset) begin
      min_l1_request_gap_r <= GAP_RST;
      timer_start_select_r <= 1'b0;
    end else if (reg_wr && reg_addr == REJ_TIMER_OFS) begin
      if (wgap < GAP_MIN) min_l1_request_gap_r <= GAP_MIN;
      else if (wgap > GAP_MAX) min_l1_request_gap_r <= GAP_MAX;
      else min_l1_request_gap_r <= wgap;
      timer_start_select_r <= reg_wdata[TSS_BIT];
    end
  end

  // request stream edge tracker: a continuous burst is one request
  // the gap rearms it, so a stream held past the gap is heard (no live-lock)
  always_ff @(posedge core_clk) begin
    if (reset) req_seen_r <= 1'b0;
    else if (!rx_req_l1) req_seen_r <= 1'b0;
    else if (state_r == ST_GAP) req_seen_r <= 1'b0;
    else if (state_r == ST_IDLE && !gap_busy && aspm_l1_en_r) req_seen_r <= 1'b1;
  end

  // entry request handshake
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (new_req && aspm_l1_en_r) begin
            if (tlp_pending) state_r <= ST_NAK;
            else state_r <= ST_ACK;
          end
        end
        ST_ACK: begin
          if (rx_eidle || !link_up_now) state_r <= ST_IDLE;
          else if (tlp_pending) state_r <= ST_IDLE;
        end
        ST_NAK: begin
          if (nak_done) state_r <= ST_GAP;
        end
        ST_GAP: begin
          if (!gap_busy && !gap_start) state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // outputs to the link layer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      send_ack <= 1'b0;
      send_nak <= 1'b0;
      enter_l1 <= 1'b0;
    end else begin
      send_ack <= (state_r == ST_IDLE && new_req && aspm_l1_en_r && !tlp_pending) ||
                  (state_r == ST_ACK && !rx_eidle && link_up_now && !tlp_pending);
      // single-cycle request for one nak message
      send_nak <= state_r == ST_IDLE && new_req && aspm_l1_en_r && tlp_pending;
      enter_l1 <= state_r == ST_ACK && rx_eidle;
    end
  end

  // L1 exit initiation
  always_ff @(posedge core_clk) begin
    if (reset) l1_exit_req <= 1'b0;
    else l1_exit_req <= in_l1 && (tlp_pending || partner_exit);
  end

  // event counters for status
  always_ff @(posedge core_clk) begin
    if (reset) begin
      acc_cnt_r <= '0;
      rej_cnt_r <= '0;
    end else begin
      if (state_r == ST_ACK && rx_eidle) acc_cnt_r <= acc_cnt_r + 32'h1;
      if (gap_start) rej_cnt_r <= rej_cnt_r + 32'h1;
    end
  end

  // read mux
  always_comb begin
    rd_nxt = '0;
    unique case (reg_addr)
      LINK_CTRL_OFS: rd_nxt = {30'h0, aspm_l1_en_r, aspm_other_r};
      REJ_TIMER_OFS: begin
        rd_nxt[GAP_LSB +: GAP_W] = min_l1_request_gap_r;
        rd_nxt[TSS_BIT] = timer_start_select_r;
      end
      STATUS_OFS: rd_nxt = {rej_cnt_r[11:0], acc_cnt_r[11:0], 2'h0, gap_busy,
                            link_up_now, 2'h0, state_r};
      default: rd_nxt = '0;
    endcase
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk) begin
    if (reset) reg_rdata <= '0;
    else if (reg_rd) reg_rdata <= rd_nxt;
    else reg_rdata <= '0;
  end

  lapc_gap_timer u_gap (
    .core_clk(core_clk),
    .reset(reset),
    .start(gap_start),
    .rx_active(rx_active),
    .alt_mode(timer_start_select_r),
    .gap(min_l1_request_gap_r),
    .busy(gap_busy)
  );

  // per-port status toward the expander
  lapc_act_hold #(.PERIOD_CYC(EXP_PERIOD)) u_act (
    .core_clk(core_clk),
    .reset(reset),
    .tlp_seen(tlp_seen),
    .link_up_now(link_up_now),
    .link_up_n(port_link_up_indicator),
    .active_n(port_activity_indicator)
  );
endmodule
